// ===== hdl/fbci_defs.vh
// Constants for the foreground branch and constant-load issue block.
`ifndef FBCI_DEFS_VH
`define FBCI_DEFS_VH

// Opcode bytes handled by this block.
`define FBCI_OP_BR_CONST        8'h00
`define FBCI_OP_BR_VIA_B        8'h01
`define FBCI_OP_BR_CON_OUT_DONE 8'h02
`define FBCI_OP_BR_CON_IN_READY 8'h03
`define FBCI_OP_BR_B_ZERO       8'h04
`define FBCI_OP_BR_B_NONZERO    8'h05
`define FBCI_OP_BR_B_POSITIVE   8'h06
`define FBCI_OP_BR_B_NEGATIVE   8'h07
`define FBCI_OP_BR_CHAN_BUSY    8'h08
`define FBCI_OP_BR_CHAN_IDLE    8'h0C
`define FBCI_OP_LOAD_A_UPPER    8'h10
`define FBCI_OP_LOAD_A_LOWER    8'h11
`define FBCI_OP_LOAD_A_FULL0    8'h12
`define FBCI_OP_LOAD_A_FULL1    8'h13
`define FBCI_OP_LIMIT           8'h14

// Issue timing, in clock periods from the issue cycle.
`define FBCI_TAKEN_CYC          4'd12
`define FBCI_FALL_CYC           4'd3
`define FBCI_FULL_CYC           4'd5
`define FBCI_A_FREE_CYC         2'd3
`define FBCI_B_DEST_WINDOW      2

// APB register byte offsets.
`define FBCI_CTRL_OFS           8'h00
`define FBCI_PC_OFS             8'h04
`define FBCI_STATUS_OFS         8'h08
`define FBCI_TAKEN_OFS          8'h0C
`define FBCI_AVAL_OFS           8'h10

// Field positions and reset values.
`define FBCI_CTRL_RUN_BIT       0
`define FBCI_CTRL_RESET         1'b0
`define FBCI_PC_RESET           16'h0000

`endif

// ===== hdl/fbci_cond.v
// Branch condition and issue-requirement decoder for one opcode byte.
`timescale 1ns/100ps
`include "fbci_defs.vh"

module fbci_cond (
   input  wire [7:0]  op,
   input  wire [31:0] b_value,
   input  wire        con_out_done,
   input  wire        con_in_full,
   input  wire [3:0]  chan_busy,
   output reg         taken,
   output reg         need_b,
   output reg         need_b_quiet,
   output reg         need_a
);

   // The low two opcode bits pick the channel for the busy and idle tests.
   wire chan_flag;          // Busy flag of the selected channel.
   wire b_is_zero;          // Whole B register equals zero.

   assign chan_flag = chan_busy[op[1:0]];
   assign b_is_zero = (b_value == 32'h0000_0000);

   // Combinational decode; only branches set taken, loads leave it clear.
   always @* begin
      taken        = 1'b0;
      need_b       = 1'b0;
      need_b_quiet = 1'b0;
      need_a       = 1'b0;
      case (op)
         `FBCI_OP_BR_CONST: begin
            taken = 1'b1;
         end
         `FBCI_OP_BR_VIA_B: begin
            taken  = 1'b1;
            need_b = 1'b1;
         end
         `FBCI_OP_BR_CON_OUT_DONE: taken = con_out_done;
         `FBCI_OP_BR_CON_IN_READY: taken = con_in_full;
         `FBCI_OP_BR_B_ZERO: begin
            taken        = b_is_zero;
            need_b_quiet = 1'b1;
         end
         `FBCI_OP_BR_B_NONZERO: begin
            taken        = ~b_is_zero;
            need_b_quiet = 1'b1;
         end
         `FBCI_OP_BR_B_POSITIVE: begin
            taken        = ~b_value[31];
            need_b_quiet = 1'b1;
         end
         `FBCI_OP_BR_B_NEGATIVE: begin
            taken        = b_value[31];
            need_b_quiet = 1'b1;
         end
         `FBCI_OP_LOAD_A_UPPER, `FBCI_OP_LOAD_A_LOWER,
         `FBCI_OP_LOAD_A_FULL0, `FBCI_OP_LOAD_A_FULL1: begin
            need_a = 1'b1;
         end
         default: begin
            // Channel tests need no register to be free.
            if (op[7:3] == 5'b00001) begin
               taken = op[2] ? ~chan_flag : chan_flag;
            end
         end
      endcase
   end

endmodule

// ===== hdl/fbci_top.v
// Issue sequencer for conditional branches and A-register constant loads.
//
// Behaviour
// - Opcode 002 branches when console output done.
// - Opcode 003 branches when console input ready.
// - Branch target comes from following two bytes.
// - Taken issues next at 12, fall-through 3.
// - Opcode 004 branches when B equals zero.
// - Opcode 005 branches when B is nonzero.
// - Opcode 006 branches when B sign clear.
// - Opcode 007 branches when B sign set.
// - B tests wait for B free, quiet two.
// - Opcodes 010-013 branch when channel busy.
// - Opcodes 014-017 branch when channel idle.
// - Console and channel branches never stall.
// - Opcode 020 loads upper A, clears lower.
// - Opcode 021 loads lower A, clears upper.
// - 16-bit loads need A free; three cycles.
// - Opcodes 022/023 load A from four bytes.
// - Full load issues next at 5, A free 3.
// - Opcode 001 jumps to B low half.
// - Opcode 000 jumps unconditionally after twelve.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "fbci_defs.vh"

module fbci_top (
   input  wire        pclk,
   input  wire        presetn,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Byte-wide instruction stream; data answers the address in the same cycle.
   output reg  [15:0] prog_addr,
   input  wire [7:0]  prog_data,
   // Status flags from neighbouring units, all on pclk.
   input  wire        con_out_done,
   input  wire        con_in_full,
   input  wire [3:0]  chan_busy,
   input  wire [31:0] b_value,
   input  wire        b_busy,
   input  wire        b_dest,
   input  wire        a_busy_ext,
   // Results.
   output reg  [31:0] a_value,
   output reg         a_load,
   output reg         issue,
   output reg         br_taken,
   output reg         ext_issue,
   output reg  [7:0]  ext_opcode
);

   // Sequencer states.
   localparam ST_ISSUE = 2'd0;   // Opcode sits in the issue position.
   localparam ST_EXEC  = 2'd1;   // Operand bytes are being consumed.
   localparam ST_WAIT  = 2'd2;   // Taken branch is waiting out its delay.

   reg  [1:0]  st_reg;           // Current sequencer state.
   reg  [1:0]  st_next;
   reg  [3:0]  step_reg;         // Clock periods since the issue cycle.
   reg  [3:0]  step_next;
   reg  [7:0]  op_reg;           // Opcode latched at issue.
   reg  [7:0]  op_next;
   reg         tk_reg;           // Branch decision latched at issue.
   reg         tk_next;
   reg  [31:0] opnd_reg;         // Operand shift register.
   reg  [31:0] opnd_next;
   reg  [15:0] pc_next;
   reg  [1:0]  a_cnt_reg;        // Remaining periods until A is free.
   reg  [1:0]  a_cnt_next;
   reg  [1:0]  b_hist_reg;       // B destination events of the last two periods.
   reg         run_reg;          // Software enable for issuing.
   reg  [15:0] taken_cnt_reg;    // Count of taken branches.
   reg  [31:0] a_value_next;
   reg         a_load_next;
   reg         issue_next;
   reg         br_taken_next;
   reg         ext_issue_next;
   reg  [3:0]  n_bytes;          // Operand bytes of the latched opcode.
   reg         issue_ok;         // Opcode in issue position may issue now.

   wire        c_taken;          // Decoder outputs for the byte at issue.
   wire        c_need_b;
   wire        c_need_b_quiet;
   wire        c_need_a;
   wire        known_op;         // Opcode belongs to this block.
   wire        a_free;
   wire        b_free;
   wire        b_quiet;
   wire        apb_wr;           // APB write commit edge.
   wire        apb_rd_setup;     // APB read setup cycle.
   wire        addr_ok;          // Address hits a register.

   // Condition decode is looked up straight from the issue byte.
   fbci_cond u_cond (
      .op           (prog_data),
      .b_value      (b_value),
      .con_out_done (con_out_done),
      .con_in_full  (con_in_full),
      .chan_busy    (chan_busy),
      .taken        (c_taken),
      .need_b       (c_need_b),
      .need_b_quiet (c_need_b_quiet),
      .need_a       (c_need_a)
   );

   assign known_op = (prog_data < `FBCI_OP_LIMIT);
   assign a_free   = (a_cnt_reg == 2'd0) & ~a_busy_ext;
   assign b_free   = ~b_busy;
   // A write to B in this period or either of the last two blocks the test.
   assign b_quiet  = ~b_dest & (b_hist_reg == 2'b00);

   // Issue gating: only B tests, the jump through B and A loads ever stall.
   always @* begin
      issue_ok = run_reg;
      if (c_need_b) begin
         issue_ok = run_reg & b_free;
      end else if (c_need_b_quiet) begin
         issue_ok = run_reg & b_free & b_quiet;
      end else if (c_need_a) begin
         issue_ok = run_reg & a_free;
      end
   end

   // Operand byte count of the opcode already issued.
   always @* begin
      case (op_reg)
         `FBCI_OP_BR_VIA_B:     n_bytes = 4'd0;
         `FBCI_OP_LOAD_A_FULL0,
         `FBCI_OP_LOAD_A_FULL1: n_bytes = 4'd4;
         default:               n_bytes = 4'd2;
      endcase
   end

   // Main sequencer: the byte stream advances one address per period, so a
   // two-byte operand naturally yields the next issue three periods later.
   always @* begin
      st_next        = st_reg;
      step_next      = step_reg;
      op_next        = op_reg;
      tk_next        = tk_reg;
      opnd_next      = opnd_reg;
      pc_next        = prog_addr;
      a_value_next   = a_value;
      a_load_next    = 1'b0;
      issue_next     = 1'b0;
      br_taken_next  = 1'b0;
      ext_issue_next = 1'b0;
      a_cnt_next     = (a_cnt_reg == 2'd0) ? 2'd0 : a_cnt_reg - 2'd1;
      case (st_reg)
         ST_ISSUE: begin
            if (run_reg & ~known_op) begin
               // Foreign opcodes are handed on and the stream steps one byte.
               ext_issue_next = 1'b1;
               pc_next        = prog_addr + 16'h0001;
            end else if (issue_ok) begin
               issue_next = 1'b1;
               op_next    = prog_data;
               tk_next    = c_taken;
               step_next  = 4'd1;
               if (c_need_a) begin
                  a_cnt_next = `FBCI_A_FREE_CYC - 2'd1;
               end
               if (prog_data == `FBCI_OP_BR_VIA_B) begin
                  opnd_next = {16'h0000, b_value[15:0]};
                  st_next   = ST_WAIT;
               end else begin
                  pc_next = prog_addr + 16'h0001;
                  st_next = ST_EXEC;
               end
            end
         end
         ST_EXEC: begin
            // Bytes shift in from the bottom, so the first one ends highest.
            opnd_next = {opnd_reg[23:0], prog_data};
            pc_next   = prog_addr + 16'h0001;
            step_next = step_reg + 4'd1;
            if (step_reg == n_bytes) begin
               if (op_reg[7:4] == 4'h1) begin
                  a_load_next = 1'b1;
                  case (op_reg)
                     `FBCI_OP_LOAD_A_UPPER:
                        a_value_next = {opnd_reg[7:0], prog_data, 16'h0000};
                     `FBCI_OP_LOAD_A_LOWER:
                        a_value_next = {16'h0000, opnd_reg[7:0], prog_data};
                     default:
                        a_value_next = {opnd_reg[23:0], prog_data};
                  endcase
                  // Next opcode follows the operands directly.
                  st_next = ST_ISSUE;
               end else if (tk_reg) begin
                  st_next = ST_WAIT;
               end else begin
                  // Pointer already sits past both address bytes.
                  st_next = ST_ISSUE;
               end
            end
         end
         ST_WAIT: begin
            step_next = step_reg + 4'd1;
            if (step_reg == `FBCI_TAKEN_CYC - 4'd1) begin
               pc_next       = opnd_reg[15:0];
               br_taken_next = 1'b1;
               st_next       = ST_ISSUE;
            end
         end
         default: begin
            st_next = ST_ISSUE;
         end
      endcase
      // Software may move the pointer only while nothing is in flight.
      if (apb_wr & (paddr == `FBCI_PC_OFS) & (st_reg == ST_ISSUE)) begin
         pc_next = pwdata[15:0];
      end
   end

   // Sequencer registers.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg     <= ST_ISSUE;
         step_reg   <= 4'h0;
         op_reg     <= 8'h00;
         tk_reg     <= 1'b0;
         opnd_reg   <= 32'h0000_0000;
         prog_addr  <= `FBCI_PC_RESET;
         a_cnt_reg  <= 2'h0;
         a_value    <= 32'h0000_0000;
         a_load     <= 1'b0;
         issue      <= 1'b0;
         br_taken   <= 1'b0;
         ext_issue  <= 1'b0;
         ext_opcode <= 8'h00;
      end else begin
         st_reg     <= st_next;
         step_reg   <= step_next;
         op_reg     <= op_next;
         tk_reg     <= tk_next;
         opnd_reg   <= opnd_next;
         prog_addr  <= pc_next;
         a_cnt_reg  <= a_cnt_next;
         a_value    <= a_value_next;
         a_load     <= a_load_next;
         issue      <= issue_next;
         br_taken   <= br_taken_next;
         ext_issue  <= ext_issue_next;
         if (ext_issue_next) begin
            ext_opcode <= prog_data;
         end
      end
   end

   // History of B destination events; two periods deep.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b_hist_reg <= 2'b00;
      end else begin
         b_hist_reg <= {b_hist_reg[0], b_dest};
      end
   end

   // APB slave: no wait states, ready and read data both from flip-flops.
   assign apb_wr       = psel & penable & pready & pwrite;
   assign apb_rd_setup = psel & ~penable & ~pwrite;
   assign addr_ok      = (paddr == `FBCI_CTRL_OFS) | (paddr == `FBCI_PC_OFS) |
                         (paddr == `FBCI_STATUS_OFS) | (paddr == `FBCI_TAKEN_OFS) |
                         (paddr == `FBCI_AVAL_OFS);

   // Ready rises in the first access cycle and drops after the commit edge.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         if (apb_rd_setup) begin
            case (paddr)
               `FBCI_CTRL_OFS:   prdata <= {31'h0000_0000, run_reg};
               `FBCI_PC_OFS:     prdata <= {16'h0000, prog_addr};
               `FBCI_STATUS_OFS: prdata <= {14'h0000, st_reg, op_reg, 4'h0, step_reg};
               `FBCI_TAKEN_OFS:  prdata <= {16'h0000, taken_cnt_reg};
               `FBCI_AVAL_OFS:   prdata <= a_value;
               default:          prdata <= 32'h0000_0000;
            endcase
         end else if (!psel) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Control register and taken-branch counter.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_reg       <= `FBCI_CTRL_RESET;
         taken_cnt_reg <= 16'h0000;
      end else begin
         if (apb_wr & (paddr == `FBCI_CTRL_OFS)) begin
            run_reg <= pwdata[`FBCI_CTRL_RUN_BIT];
         end
         // Writing the counter clears it, but a taken branch in the same
         // cycle still counts so no event is lost.
         if (br_taken_next) begin
            if (apb_wr & (paddr == `FBCI_TAKEN_OFS)) begin
               taken_cnt_reg <= 16'h0001;
            end else begin
               taken_cnt_reg <= taken_cnt_reg + 16'h0001;
            end
         end else if (apb_wr & (paddr == `FBCI_TAKEN_OFS)) begin
            taken_cnt_reg <= 16'h0000;
         end
      end
   end

endmodule

// ===== tb/fbci_top_sva.sv
// Checker for the branch and constant-load issue sequencer.
`timescale 1ns/100ps
module fbci_top_sva (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire [15:0] prog_addr,
   input wire [7:0]  prog_data,
   input wire        con_out_done,
   input wire        con_in_full,
   input wire [3:0]  chan_busy,
   input wire [31:0] b_value,
   input wire        b_busy,
   input wire        b_dest,
   input wire        a_busy_ext,
   input wire [31:0] a_value,
   input wire        a_load,
   input wire        issue,
   input wire        br_taken
);
   reg  [7:0]  op_d;    // Byte at the issue position one cycle ago.
   reg         cond_d;  // Branch condition worked out from that cycle's flags.
   reg  [15:0] bl_d;    // Low half of B from that cycle.
   // The issue pulse trails the opcode by one cycle, so each class is judged on op_d.
   wire br_d = issue && (op_d < 8'h10);
   wire bt_d = issue && (op_d[7:2] == 6'h01);
   wire l16_d = issue && (op_d[7:1] == 7'h08);
   wire l32_d = issue && (op_d[7:1] == 7'h09);
   // Independent model of every branch condition.
   function automatic logic cond_of(input logic [7:0] op);
      case (op[3:0])
         4'h2: cond_of = con_out_done;
         4'h3: cond_of = con_in_full;
         4'h4: cond_of = (b_value == 32'h00000000);
         4'h5: cond_of = (b_value != 32'h00000000);
         4'h6: cond_of = !b_value[31];
         4'h7: cond_of = b_value[31];
         default: cond_of = op[3] ? (chan_busy[op[1:0]] ^ op[2]) : 1'b1;
      endcase
   endfunction
   // Flags are captured in the cycle the opcode stands at the issue position.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_d <= 8'h00;
         cond_d <= 1'b0;
         bl_d <= 16'h0000;
      end else begin
         op_d <= prog_data;
         cond_d <= cond_of(prog_data);
         bl_d <= b_value[15:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A taken branch waits ten quiet cycles, then lands.
   sequence s_taken_wait;
      !br_taken [*8] ##1 !br_taken [*2] ##1 br_taken;
   endsequence
   taken_delay_a: assert property (br_d && cond_d |=> s_taken_wait)
      else $error("taken branch landed at the wrong cycle");
   fall_skip_a: assert property (br_d && !cond_d |-> ##2
      (!br_taken && prog_addr == $past(prog_addr, 3) + 16'h0003))
      else $error("fall-through did not skip the address bytes");
   target_order_a: assert property (br_d && cond_d && op_d != 8'h01 |-> ##11
      prog_addr == {$past(prog_data, 11), $past(prog_data, 10)})
      else $error("branch target not assembled high byte first");
   via_b_a: assert property (issue && op_d == 8'h01 |-> ##11
      (br_taken && prog_addr == $past(bl_d, 11)))
      else $error("jump through B went to the wrong address");
   b_quiet_a: assert property (bt_d |->
      !$past(b_busy) && !$past(b_dest) && !$past(b_dest, 2) && !$past(b_dest, 3))
      else $error("B test issued while B busy or recently written");
   a_free_a: assert property ((l16_d || l32_d) |-> !$past(a_busy_ext))
      else $error("constant load issued while A held elsewhere");
   load16_next_a: assert property (l16_d |-> ##2 prog_addr == $past(prog_addr, 3) + 16'h0003)
      else $error("short constant load did not advance three bytes");
   load32_a: assert property (l32_d |-> ##4 (a_load && a_value ==
      {$past(prog_data, 4), $past(prog_data, 3), $past(prog_data, 2), $past(prog_data, 1)}))
      else $error("full constant load wrong value or time");
   load32_next_a: assert property (l32_d |-> ##4 prog_addr == $past(prog_addr, 5) + 16'h0005)
      else $error("full constant load did not free the stream after five");
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("register access not answered in first access cycle");
endmodule
bind fbci_top fbci_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .prog_addr(prog_addr), .prog_data(prog_data),
   .con_out_done(con_out_done), .con_in_full(con_in_full), .chan_busy(chan_busy),
   .b_value(b_value), .b_busy(b_busy), .b_dest(b_dest), .a_busy_ext(a_busy_ext),
   .a_value(a_value), .a_load(a_load), .issue(issue), .br_taken(br_taken));

// ===== tb/fbci_prog_mem.sv
// Byte-wide program memory that feeds the instruction stream.
`timescale 1ns/100ps
module fbci_prog_mem (
   input  wire [15:0] prog_addr,
   output wire [7:0]  prog_data
);
   logic [7:0] mem [0:65535];  // Loaded by the bench between runs.
   // Unwritten bytes hold a foreign opcode, so a stray run never issues here.
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h14;
      end
   end
   // The byte answers its address in the same cycle, as the sequencer expects.
   assign prog_data = mem[prog_addr];
endmodule

// ===== tb/fg_branch_const_load_issue_bench.sv
// Self-checking bench for the branch and constant-load issue sequencer.
`timescale 1ns/100ps
`include "fbci_defs.vh"
module fg_branch_const_load_issue_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        con_out_done, con_in_full, b_busy, b_dest, a_busy_ext;
   logic        a_load, issue, br_taken, ext_issue;
   logic [7:0]  paddr, prog_data, ext_opcode;
   logic [15:0] prog_addr;
   logic [3:0]  chan_busy;
   logic [31:0] pwdata, prdata, b_value, a_value, rd;
   integer      fails, cmp_count;
   fbci_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
      .con_out_done(con_out_done), .con_in_full(con_in_full), .chan_busy(chan_busy),
      .b_value(b_value), .b_busy(b_busy), .b_dest(b_dest), .a_busy_ext(a_busy_ext),
      .a_value(a_value), .a_load(a_load), .issue(issue), .br_taken(br_taken),
      .ext_issue(ext_issue), .ext_opcode(ext_opcode));
   fbci_prog_mem u_mem (.prog_addr(prog_addr), .prog_data(prog_data));
   // 20 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Verdict and end of run.
   task tally_and_finish;
      begin
         if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // A wait that ran out counts against the run and ends it.
   task give_up;
      begin
         chk(32'h0, 32'h1);
         tally_and_finish;
      end
   endtask
   // One APB transfer; the request stands until pready is sampled high.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= a;
         pwdata <= wd;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n = n + 1;
         end
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (n >= 20) give_up;
      end
   endtask
   // Stop, let the sequencer settle, point it at p and start it.
   task exec_start(input logic [15:0] p);
      begin
         apb(1'b1, `FBCI_CTRL_OFS, 32'h0);
         repeat (4) @(posedge pclk);
         apb(1'b1, `FBCI_PC_OFS, {16'h0000, p});
         apb(1'b1, `FBCI_CTRL_OFS, 32'h1);
      end
   endtask
   task wait_issue;
      integer n;
      begin
         n = 0;
         @(negedge pclk);
         while (issue !== 1'b1 && n < 40) begin
            @(negedge pclk);
            n = n + 1;
         end
         if (n >= 40) give_up;
      end
   endtask
   task stalled(input integer k);
      repeat (k) begin
         @(negedge pclk);
         chk({31'h0, issue}, 32'h0);
      end
   endtask
   // One branch at p with target t; exp says whether it should be taken.
   task br_run(input logic [7:0] op, input logic [15:0] p, t, input logic exp);
      begin
         u_mem.mem[p] = op;
         u_mem.mem[p + 16'h1] = t[15:8];
         u_mem.mem[p + 16'h2] = t[7:0];
         exec_start(p);
         wait_issue;
         if (exp) begin
            repeat (11) @(negedge pclk);
            chk({16'h0, prog_addr}, {16'h0, t});
         end else begin
            repeat (2) @(negedge pclk);
            chk({16'h0, prog_addr}, {16'h0, p + 16'h3});
         end
         chk({31'h0, br_taken}, {31'h0, exp});
      end
   endtask
   // Every conditional opcode both ways; non-B branches run with the B and A busy flags up.
   task t_cond;
      integer op, pol;
      logic [3:0] sel;
      begin
         for (op = 0; op < 16; op = op + 1) begin
            for (pol = 0; pol < 2 && op != 1; pol = pol + 1) begin
               sel = 4'h1 << op[1:0];
               @(posedge pclk);
               b_busy <= (op < 4 || op > 7);
               a_busy_ext <= 1'b1;
               con_out_done <= pol[0];
               con_in_full <= pol[0];
               chan_busy <= ((op >= 12) ^ pol[0]) ? sel : ~sel;
               case (op)
                  4: b_value <= pol[0] ? 32'h0 : 32'h80000000;
                  5: b_value <= pol[0] ? 32'h00010000 : 32'h0;
                  6: b_value <= pol[0] ? 32'h0 : 32'h80000000;
                  7: b_value <= pol[0] ? 32'hFFFFFFFF : 32'h7FFFFFFF;
                  default: b_value <= 32'h0;
               endcase
               br_run(op[7:0], 16'h1000 + 16'(op * 64 + pol * 32), 16'h5A00 + 16'(op * 2 + pol),
                  op == 0 || pol == 1);
            end
         end
         @(posedge pclk);
         a_busy_ext <= 1'b0;  // B stays busy: the next scenario starts stalled on it.
      end
   endtask
   // Jump through B waits for B free and takes only the low half.
   task t_via_b;
      begin
         u_mem.mem[16'h2000] = 8'h01;
         b_value <= 32'hABCD6E4C;
         b_busy <= 1'b1;
         exec_start(16'h2000);
         stalled(3);
         @(posedge pclk);
         b_busy <= 1'b0;
         wait_issue;
         repeat (11) @(negedge pclk);
         chk({16'h0, prog_addr}, 32'h00006E4C);
         chk({31'h0, br_taken}, 32'h1);
      end
   endtask
   // A B test waits three cycles after B was last named as a destination.
   task t_quiet;
      begin
         u_mem.mem[16'h2100] = 8'h05;
         u_mem.mem[16'h2101] = 8'h7C;
         u_mem.mem[16'h2102] = 8'h35;
         @(posedge pclk);
         b_busy <= 1'b1;
         exec_start(16'h2100);
         stalled(3);
         @(posedge pclk);
         b_busy <= 1'b0;
         b_dest <= 1'b1;
         @(posedge pclk);
         b_dest <= 1'b0;
         stalled(3);
         @(negedge pclk);
         chk({31'h0, issue}, 32'h1);
         repeat (11) @(negedge pclk);
         chk({16'h0, prog_addr}, 32'h00007C35);
      end
   endtask
   // Back-to-back constant loads: upper, lower, then both full-width codes.
   task t_loads;
      logic [7:0] prg [0:15] = '{8'h10, 8'h12, 8'h34, 8'h11, 8'h56, 8'h78, 8'h12, 8'h89,
                                 8'hAB, 8'hCD, 8'hEF, 8'h13, 8'h01, 8'h02, 8'h03, 8'h04};
      logic [31:0] av [$];
      logic [17:0] im, lm;
      integer k;
      begin
         for (k = 0; k < 16; k = k + 1) u_mem.mem[16'h3000 + 16'(k)] = prg[k];
         @(posedge pclk);
         a_busy_ext <= 1'b1;
         exec_start(16'h3000);
         stalled(3);
         @(posedge pclk);
         a_busy_ext <= 1'b0;
         wait_issue;
         im = 18'h0;
         lm = 18'h0;
         for (k = 2; k < 18; k = k + 1) begin
            @(negedge pclk);
            im[k] = issue;
            lm[k] = a_load;
            if (a_load === 1'b1) av.push_back(a_value);
         end
         chk({14'h0, im}, 32'h00001090);
         chk({26'h0, lm[16:11]}, 32'h21);
         chk({23'h0, ext_issue, ext_opcode}, 32'h114);
         chk(av.size(), 32'h4);
         chk(av[0], 32'h12340000);
         chk(av[1], 32'h00005678);
         chk(av[2], 32'h89ABCDEF);
         chk(av[3], 32'h01020304);
      end
   endtask
   // Reset values, an unmapped address and the read-only A register.
   task t_regs(input logic late);
      begin
         if (!late) begin
            apb(1'b0, `FBCI_CTRL_OFS, 32'h0);
            chk(rd, 32'h0);
            apb(1'b0, `FBCI_PC_OFS, 32'h0);
            chk(rd, 32'h0);
            apb(1'b0, 8'h40, 32'h0);
            chk({31'h0, er}, 32'h1);
         end else begin
            apb(1'b1, `FBCI_AVAL_OFS, 32'hFFFFFFFF);
            apb(1'b0, `FBCI_AVAL_OFS, 32'h0);
            chk(rd, 32'h01020304);
            chk({31'h0, er}, 32'h0);
         end
      end
   endtask
   initial begin
      fails = 0;
      cmp_count = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, con_out_done, con_in_full, b_busy, b_dest, a_busy_ext} = 8'h00;
      {paddr, pwdata, chan_busy, b_value} = 76'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs(1'b0);
      t_cond;
      t_via_b;
      t_quiet;
      t_loads;
      t_regs(1'b1);
      tally_and_finish;
   end
   // Overall watchdog.
   initial begin
      repeat (90000) @(posedge pclk);
      give_up;
   end
endmodule
